// >>> pkg/cff_pkg.sv
// ==========================================================
// Shared constants and types
package cff_pkg;

   localparam int unsigned AW = 12;
   localparam int unsigned NFIFO = 32;
   localparam int unsigned NFILT = 2;

   // Register byte addresses
   localparam logic [AW-1:0] OFS_FILT = 12'h000;
   localparam logic [AW-1:0] OFS_EVT = 12'h004;
   localparam logic [AW-1:0] OFS_MASK = 12'h008;
   localparam logic [AW-1:0] OFS_DIR = 12'h00C;
   localparam logic [AW-1:0] OFS_FIFO_BASE = 12'h080;
   localparam logic [AW-1:0] OFS_FIFO_END = 12'h100;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 6;

   // Filter byte layout
   localparam int unsigned FB_EN = 7;
   localparam int unsigned FILT_BYTE = 8;

   // FIFO event register layout
   localparam int unsigned B_TX_SPACE_F = 10;
   localparam int unsigned B_TX_HALF_F = 9;
   localparam int unsigned B_TX_DRAIN_F = 8;
   localparam int unsigned B_RX_OVR_F = 3;
   localparam int unsigned B_RX_PACK_F = 2;
   localparam int unsigned B_RX_HALF_F = 1;
   localparam int unsigned B_RX_PEND_F = 0;
   localparam int unsigned B_TX_SPACE_IE = 26;
   localparam int unsigned B_TX_DRAIN_IE = 24;
   localparam int unsigned B_RX_OVR_IE = 19;
   localparam int unsigned B_RX_PACK_IE = 18;
   localparam int unsigned B_RX_PEND_IE = 16;
   localparam int unsigned IE_SHIFT = 16;
   localparam logic [31:0] IE_MASK = 32'h070F_0000;
   localparam logic [31:0] FLAG_MASK = 32'h0000_070F;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic filter_enable_bit;
      logic [1:0] mask_pick;
      logic [4:0] dest_fifo;
   } cff_filt_t;

   typedef struct packed {
      logic [NFIFO-1:0] full;
      logic [NFIFO-1:0] half;
      logic [NFIFO-1:0] empty;
      logic [NFIFO-1:0] arrive;
   } cff_fifo_stat_t;

endpackage

// >>> design/cff_axil.sv
`timescale 1ns/100ps
// ==========================================================
// AXI4-Lite slave front end, one write and one read at a time
module cff_axil
   import cff_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic wr_pulse,
   output logic [AW-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic rd_pulse,
   output logic [AW-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);

   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;

   assign s_axi_awready = !aw_full_r;
   assign s_axi_wready = !w_full_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   assign wr_pulse = aw_full_r && w_full_r && !bvalid_r;
   assign wr_addr = awaddr_r;
   assign wr_data = wdata_r;
   assign wr_strb = wstrb_r;
   assign rd_pulse = s_axi_arvalid && !rvalid_r;
   assign rd_addr = s_axi_araddr;

   always_comb begin
      aw_full_nxt = aw_full_r;
      w_full_nxt = w_full_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid && !aw_full_r) begin
         aw_full_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r) begin
         w_full_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_pulse) begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_pulse) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_data;
         rresp_nxt = rd_err ? RESP_SLVERR : RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

endmodule

// >>> design/cff_top.sv
`timescale 1ns/100ps
// ==========================================================
// Functional notes
// [R1] Each filter has an enable bit; filter a's sits at bit 7.
// [R2] A two-bit mask pick chooses acceptance mask zero to three.
// [R3] A five-bit field names the FIFO that takes matching messages.
// [R4] Mask pick and FIFO fields change only while the filter is off.
// [R5] Filter b uses bits 15, 14-13 and 12-8; filter a the low byte.
// [R6] Transmit enables: space at 26, half at 25, drained at 24.
// [R7] Receive enables 19..16: overrun, packed, half, pending.
// [R8] In transmit mode bit 10 reads one while the FIFO has room.
// [R9] In receive mode bit 10 always reads zero.
// [R10] Fill-state flags are read-only and follow the FIFO live.
// [R11] Unassigned bits of the FIFO register read zero, ignore writes.
// [R12] Overrun is set on arrival at a full FIFO, cleared by writing 0; the code sets it in receive mode only.
// [R13] A FIFO requests an interrupt when a flag and its enable meet.
module cff_top
   import cff_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire cff_fifo_stat_t fifo_stat,
   output cff_filt_t filter_a_cfg,
   output cff_filt_t filter_b_cfg,
   output logic [NFIFO-1:0] fifo_direction_transmit,
   output logic [NFIFO-1:0] fifo_irq,
   output logic irq
);

   // ==========================================================
   // Decode helpers
   function automatic logic fifo_hit(input logic [AW-1:0] a);
      return (a >= OFS_FIFO_BASE) && (a < OFS_FIFO_END);
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = {8{s[b]}};
      end
      return m;
   endfunction

   // ==========================================================
   // Bus front end
   logic wr_pulse, wr_err, rd_pulse, rd_err;
   logic [AW-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [IDX_MSB-IDX_LSB:0] wr_idx, rd_idx;

   assign wr_idx = wr_addr[IDX_MSB:IDX_LSB];
   assign rd_idx = rd_addr[IDX_MSB:IDX_LSB];

   cff_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .wr_pulse(wr_pulse),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_pulse(rd_pulse),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // ==========================================================
   // Register state
   cff_filt_t filt_r [NFILT];
   cff_filt_t filt_nxt [NFILT];
   logic [31:0] en_r [NFIFO];
   logic [31:0] en_nxt [NFIFO];
   logic [31:0] flags [NFIFO];
   logic [NFIFO-1:0] dir_r, dir_nxt, mask_r, mask_nxt;
   logic [NFIFO-1:0] evt_r, evt_nxt, evt_clr;
   logic [NFIFO-1:0] ovf_r, ovf_nxt, ovf_set, ovf_clr;
   logic [31:0] lm;

   assign filter_a_cfg = filt_r[0];
   assign filter_b_cfg = filt_r[1];
   assign fifo_direction_transmit = dir_r;
   assign irq = |(evt_r & mask_r);

   // ==========================================================
   // Live flags and per-FIFO requests
   for (genvar n = 0; n < NFIFO; n++) begin : g_fifo
      logic tx;
      assign tx = dir_r[n];
      always_comb begin
         flags[n] = '0;
         flags[n][B_TX_SPACE_F] = tx && !fifo_stat.full[n]; // R8 R9 R10
         flags[n][B_TX_HALF_F] = tx && fifo_stat.half[n]; // R10
         flags[n][B_TX_DRAIN_F] = tx && fifo_stat.empty[n]; // R10
         flags[n][B_RX_OVR_F] = ovf_r[n]; // R12
         flags[n][B_RX_PACK_F] = !tx && fifo_stat.full[n]; // R10
         flags[n][B_RX_HALF_F] = !tx && fifo_stat.half[n]; // R10
         flags[n][B_RX_PEND_F] = !tx && !fifo_stat.empty[n]; // R10
      end
      assign ovf_set[n] = !tx && fifo_stat.arrive[n]
         && fifo_stat.full[n]; // R12
      assign fifo_irq[n] = |((en_r[n] >> IE_SHIFT) & flags[n]); // R13
   end

   // ==========================================================
   // Register writes
   always_comb begin
      lm = lane_mask(wr_strb);
      filt_nxt = filt_r;
      en_nxt = en_r;
      dir_nxt = dir_r;
      mask_nxt = mask_r;
      evt_clr = '0;
      ovf_clr = '0;
      wr_err = 1'b0;
      if (wr_pulse) begin
         if (wr_addr == OFS_FILT) begin
            for (int i = 0; i < NFILT; i++) begin
               if (wr_strb[i]) begin
                  filt_nxt[i].filter_enable_bit =
                     wr_data[FILT_BYTE*i+FB_EN]; // R1 R5
                  if (!filt_r[i].filter_enable_bit) begin // R4
                     filt_nxt[i] =
                        cff_filt_t'(wr_data[FILT_BYTE*i +: FILT_BYTE]); // R2 R3
                  end
               end
            end
         end else if (wr_addr == OFS_EVT) begin
            evt_clr = wr_data & lm;
         end else if (wr_addr == OFS_MASK) begin
            mask_nxt = (mask_r & ~lm) | (wr_data & lm);
         end else if (wr_addr == OFS_DIR) begin
            dir_nxt = (dir_r & ~lm) | (wr_data & lm);
         end else if (fifo_hit(wr_addr)) begin
            en_nxt[wr_idx] = (en_r[wr_idx] & ~(lm & IE_MASK))
               | (wr_data & lm & IE_MASK); // R6 R7 R11
            if (wr_strb[0] && !wr_data[B_RX_OVR_F]) begin
               ovf_clr[wr_idx] = 1'b1; // R12
            end
         end else begin
            wr_err = 1'b1;
         end
      end
      // Hardware set beats software clear
      ovf_nxt = ovf_set | (ovf_r & ~ovf_clr); // R12
      evt_nxt = fifo_irq | (evt_r & ~evt_clr);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NFILT; i++) begin
            filt_r[i] <= '0;
         end
         for (int n = 0; n < NFIFO; n++) begin
            en_r[n] <= '0;
         end
         dir_r <= '0;
         mask_r <= '0;
         evt_r <= '0;
         ovf_r <= '0;
      end else begin
         filt_r <= filt_nxt;
         en_r <= en_nxt;
         dir_r <= dir_nxt;
         mask_r <= mask_nxt;
         evt_r <= evt_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   // ==========================================================
   // Register reads
   always_comb begin
      rd_data = '0;
      rd_err = 1'b0;
      if (rd_addr == OFS_FILT) begin
         rd_data[2*FILT_BYTE-1:0] = {filt_r[1], filt_r[0]}; // R5
      end else if (rd_addr == OFS_EVT) begin
         rd_data = evt_r;
      end else if (rd_addr == OFS_MASK) begin
         rd_data = mask_r;
      end else if (rd_addr == OFS_DIR) begin
         rd_data = dir_r;
      end else if (fifo_hit(rd_addr)) begin
         rd_data = (en_r[rd_idx] & IE_MASK)
            | (flags[rd_idx] & FLAG_MASK); // R11
      end else begin
         rd_err = 1'b1;
      end
   end

   // ==========================================================
   // Checks
   logic filt_wr0, filt_wr1, fifo0_wr, fifo0_rd, fifo1_rd;
   assign filt_wr0 = wr_pulse && wr_addr == OFS_FILT && wr_strb[0];
   assign filt_wr1 = wr_pulse && wr_addr == OFS_FILT && wr_strb[1];
   assign fifo0_wr = wr_pulse && wr_addr == OFS_FIFO_BASE;
   assign fifo0_rd = rd_pulse && rd_addr == OFS_FIFO_BASE;
   assign fifo1_rd = rd_pulse && fifo_hit(rd_addr) && rd_idx == 5'h01;

   filt_en_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
      filt_wr0 |=> filter_a_cfg.filter_enable_bit == $past(wr_data[FB_EN]))
      else $error("filter a enable not written");

   mask_pick_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      filt_wr1 && !filter_b_cfg.filter_enable_bit
      |=> filter_b_cfg.mask_pick == $past(wr_data[14:13]))
      else $error("filter b mask pick not written");

   dest_fifo_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      filt_wr0 && !filter_a_cfg.filter_enable_bit
      |=> filter_a_cfg.dest_fifo == $past(wr_data[4:0]))
      else $error("filter a destination not written");

   filt_lock_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      filt_wr0 && filter_a_cfg.filter_enable_bit
      |=> $stable(filter_a_cfg.mask_pick) && $stable(filter_a_cfg.dest_fifo))
      else $error("locked filter fields changed");

   filt_b_pos_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      filt_wr1 && !filter_b_cfg.filter_enable_bit
      |=> filter_b_cfg == $past(wr_data[15:8]))
      else $error("filter b byte misplaced");

   tx_enable_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
      fifo0_wr && wr_strb[3]
      |=> en_r[0][B_TX_SPACE_IE:B_TX_DRAIN_IE] == $past(wr_data[26:24]))
      else $error("transmit enables not written");

   rx_enable_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      fifo0_wr && wr_strb[2]
      |=> en_r[0][B_RX_OVR_IE:B_RX_PEND_IE] == $past(wr_data[19:16]))
      else $error("receive enables not written");

   tx_space_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      fifo0_rd && dir_r[0]
      |=> s_axi_rvalid && s_axi_rdata[10] == !$past(fifo_stat.full[0]))
      else $error("transmit space flag wrong");

   rx_no_space_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
      fifo0_rd && !dir_r[0] |=> !s_axi_rdata[10])
      else $error("space flag set in receive mode");

   live_full_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
      fifo1_rd && !dir_r[1]
      |=> s_axi_rdata[B_RX_PACK_F] == $past(fifo_stat.full[1])
         && s_axi_rdata[B_RX_PEND_F] == !$past(fifo_stat.empty[1]))
      else $error("receive fill flags not live");

   reserved_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
      fifo0_rd |=> (s_axi_rdata & ~(IE_MASK | FLAG_MASK)) == 32'h0)
      else $error("reserved bits read non-zero");

   ovf_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      !dir_r[1] && fifo_stat.arrive[1] && fifo_stat.full[1]
      |=> ovf_r[1] ##1 (ovf_r[1] || $past(ovf_clr[1])))
      else $error("overrun flag not held");

   ovf_req_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      ovf_r[1] && en_r[1][B_RX_OVR_IE] |-> fifo_irq[1] ##1 evt_r[1])
      else $error("overrun request missing");

endmodule

// >>> verif/cff_fifo_model.sv
`timescale 1ns/100ps
// ==========================================================
// Message FIFO fill model, one counter per FIFO
module cff_fifo_model
   import cff_pkg::*;
#(
   parameter int DEPTH = 4
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic push,
   input wire logic pop,
   input wire logic [4:0] sel,
   output cff_fifo_stat_t stat
);
   int cnt [NFIFO];

   // A push into a full FIFO is offered but dropped
   always_ff @(posedge aclk) begin
      for (int i = 0; i < NFIFO; i++) begin
         if (!aresetn) begin
            cnt[i] <= 0;
         end else if (push && sel == i && cnt[i] < DEPTH) begin
            cnt[i] <= cnt[i] + 1;
         end else if (pop && sel == i && cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NFIFO; i++) begin
         stat.full[i] = cnt[i] == DEPTH;
         stat.half[i] = cnt[i] >= DEPTH / 2;
         stat.empty[i] = cnt[i] == 0;
         stat.arrive[i] = push && sel == i;
      end
   end
endmodule

// >>> verif/tb.sv
`timescale 1ns/100ps
// ==========================================================
// Register, event and filter bench
module tb
   import cff_pkg::*;
;
   typedef struct {
      logic [AW-1:0] a;
      logic [31:0] d;
      logic [3:0] s;
      logic [31:0] q;
      logic [1:0] e;
   } cff_row_t;

   logic aclk = 0;
   logic aresetn = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
   logic [31:0] s_axi_rdata, rv;
   logic [NFIFO-1:0] fifo_direction_transmit, fifo_irq;
   cff_filt_t filter_a_cfg, filter_b_cfg;
   cff_fifo_stat_t fifo_stat;
   logic push = 0, pop = 0;
   logic [4:0] sel = 0;
   int miscompares = 0;
   int check_count = 0;

   cff_row_t rows [7] = '{
      '{OFS_FILT, 32'h0000_7F60, 4'hF, 32'h0000_7F60, RESP_OKAY},
      '{OFS_FIFO_BASE, 32'hFFFF_FFFF, 4'hF, 32'h070F_0000, RESP_OKAY},
      '{12'h084, 32'hFFFF_FFFF, 4'h4, 32'h000F_0000, RESP_OKAY},
      '{12'h0FC, 32'hFFFF_FFFF, 4'h8, 32'h0700_0000, RESP_OKAY},
      '{12'h010, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, RESP_SLVERR},
      '{OFS_MASK, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF, RESP_OKAY},
      '{OFS_DIR, 32'h0000_0001, 4'hF, 32'h0000_0001, RESP_OKAY}
   };

   always #4 aclk = ~aclk;

   cff_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .fifo_stat,
      .filter_a_cfg, .filter_b_cfg, .fifo_direction_transmit,
      .fifo_irq, .irq);

   cff_fifo_model #(.DEPTH(4)) fifo_side (.aclk, .aresetn, .push, .pop,
      .sel, .stat(fifo_stat));

   // ==========================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic tmo();
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      report_and_stop();
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) tmo();
   endtask

   task automatic rd(input logic [AW-1:0] a);
      int n;
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 40) tmo();
   endtask

   // Push (p = 1) or pop n messages on one FIFO
   task automatic fop(input logic p, input logic [4:0] f, input int n);
      @(posedge aclk);
      push <= p;
      pop <= !p;
      sel <= f;
      repeat (n) @(posedge aclk);
      push <= 1'b0;
      pop <= 1'b0;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         wr(rows[i].a, rows[i].d, rows[i].s);
         chk(32'(br), 32'(rows[i].e));
         rd(rows[i].a);
         chk(rv, rows[i].q);
         chk(32'(rr), 32'(rows[i].e));
      end
      $display("test rows done");

      chk(32'(fifo_irq[0]), 32'h1);
      rd(OFS_FIFO_BASE);
      chk(rv, 32'h070F_0500);
      fop(1'b1, 5'h00, 4);
      rd(OFS_FIFO_BASE);
      chk(rv, 32'h070F_0200);
      fop(1'b0, 5'h00, 4);
      $display("test transmit flags done");

      fop(1'b1, 5'h01, 4);
      rd(12'h084);
      chk(rv, 32'h000F_0007);
      fop(1'b1, 5'h01, 1);
      rd(12'h084);
      chk(rv, 32'h000F_000F);
      fop(1'b0, 5'h01, 4);
      rd(12'h084);
      chk(rv, 32'h000F_0008);
      chk(32'(fifo_irq[1]), 32'h1);
      wr(12'h084, 32'h000F_0000, 4'h1);
      rd(12'h084);
      chk(rv, 32'h000F_0000);
      chk(32'(fifo_irq[1]), 32'h0);
      $display("test receive flags done");

      wr(OFS_MASK, 32'h0000_0000, 4'hF);
      chk(32'(irq), 32'h0);
      wr(OFS_MASK, 32'h0000_0001, 4'hF);
      chk(32'(irq), 32'h1);
      rd(OFS_EVT);
      chk(rv, 32'h0000_0003);
      wr(OFS_FIFO_BASE, 32'h0000_0000, 4'hF);
      wr(OFS_EVT, 32'hFFFF_FFFF, 4'hF);
      rd(OFS_EVT);
      chk(rv, 32'h0000_0000);
      chk(32'(irq), 32'h0);
      $display("test interrupt done");

      wr(OFS_FILT, 32'h0000_00E1, 4'h1);
      chk(32'(filter_a_cfg), 32'h0000_00E1);
      wr(OFS_FILT, 32'h0000_0080, 4'h1);
      chk(32'(filter_a_cfg), 32'h0000_00E1);
      wr(OFS_FILT, 32'h0000_0061, 4'h1);
      chk(32'(filter_a_cfg), 32'h0000_0061);
      chk(32'(filter_b_cfg), 32'h0000_007F);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_FILT, {24'h0, 1'b0, 2'(m), 5'h1F}, 4'h1);
         chk(32'(filter_a_cfg.mask_pick), 32'(m));
         chk(32'(filter_a_cfg.dest_fifo), 32'h1F);
      end
      $display("test filters done");

      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      chk(32'(irq), 32'h0);
      chk(fifo_direction_transmit, 32'h0);
      rd(OFS_FILT);
      chk(rv, 32'h0);
      rd(OFS_FIFO_BASE);
      chk(rv, 32'h0);
      $display("test reset done");
      report_and_stop();
   end
endmodule
